// >>> bench/ssit_timer_props.sv
// Purpose: port checks for the slow interval timer
// Assumes: one clock domain, synchronous active-high reset
// Notes:   quiet_reg counts edges since the slow pin last rose
`timescale 1ns/1ps
`default_nettype none
module ssit_timer_props (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       i_slow_clock,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic       i_sfr_wr,
  input wire logic       i_sfr_rd,
  input wire logic       i_irq_service,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic       o_interval_irq,
  input wire logic       o_clear_pending
);
  logic       slow_q_reg;
  logic [3:0] quiet_reg;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ****************
  // helper and rules
  // ****************
  // age of the last slow pin rise, saturating at 15
  always_ff @(posedge i_clk) begin
    slow_q_reg <= i_slow_clock;
    if (i_rst || (i_slow_clock && !slow_q_reg)) begin
      quiet_reg <= 4'h0;
    end else if (quiet_reg != 4'hF) begin
      quiet_reg <= quiet_reg + 4'h1;
    end
  end
  sequence s_flag_wr_clear;
    i_sfr_wr && i_sfr_addr == ssit_pkg::ADDR_FLAG && !i_sfr_wdata[0];
  endsequence
  sequence s_clear_req;
    i_sfr_wr && i_sfr_addr == ssit_pkg::ADDR_AUX && i_sfr_wdata[2];
  endsequence
  // a reload write, one quiet cycle, then a read of the same register
  sequence s_reload_wr_rd;
    (i_sfr_wr && i_sfr_addr == ssit_pkg::ADDR_RELOAD) ##1 !i_sfr_wr ##1
    (i_sfr_rd && !i_sfr_wr && i_sfr_addr == ssit_pkg::ADDR_RELOAD);
  endsequence
  // the read returns the data written three cycles before the answer
  property p_reload;
    s_reload_wr_rd |=> o_sfr_rdata == $past(i_sfr_wdata, 3);
  endproperty
  chk_reset_quiet: assert property (disable iff (1'b0) i_rst |=>
    o_sfr_rdata == 8'h00 && !o_interval_irq && !o_clear_pending)
    else $error("outputs not idle after reset");
  chk_rdata_holds: assert property (!i_sfr_rd |=> $stable(o_sfr_rdata))
    else $error("read data moved without a read");
  chk_mid_top_zero: assert property (i_sfr_rd && i_sfr_addr == 8'hB5 |=>
    !o_sfr_rdata[7]) else $error("mid count bit 7 not zero");
  chk_flag_upper_zero: assert property (i_sfr_rd && i_sfr_addr == 8'h95 |=>
    o_sfr_rdata[7:1] == 7'h00) else $error("flag register upper bits set");
  chk_reload_readback: assert property (p_reload)
    else $error("reload value not read back");
  chk_service_clears: assert property (i_irq_service && quiet_reg >= 4'h8 |->
    ##2 !o_interval_irq) else $error("service entry left flag set");
  chk_fe_write_clears: assert property (s_flag_wr_clear ##0 quiet_reg >= 4'h8 |->
    ##2 !o_interval_irq) else $error("flag write left flag set");
  chk_irq_after_slow: assert property ($rose(o_interval_irq) |->
    quiet_reg >= 4'h3 && quiet_reg <= 4'h8) else $error("flag rose away from slow edge");
  chk_clear_request: assert property (s_clear_req |-> ##2 o_clear_pending)
    else $error("clear request not pending");
  chk_clear_drops: assert property ($rose(o_clear_pending) |->
    ##[1:40] !o_clear_pending) else $error("clear request never applied");
endmodule
bind ssit_timer ssit_timer_props u_ssit_timer_props (.i_clk(i_clk), .i_rst(i_rst),
  .i_slow_clock(i_slow_clock), .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata),
  .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_irq_service(i_irq_service),
  .o_sfr_rdata(o_sfr_rdata), .o_interval_irq(o_interval_irq),
  .o_clear_pending(o_clear_pending));
`default_nettype wire

// >>> bench/tb_top.sv
// Purpose: self-checking bench for the slow interval timer
// Assumes: slow pin period of 8 system cycles, or 5 in the fast filler runs
// Notes:   overflow and trim carries need too many slow cycles to reach here
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       i_clk;
  logic       i_rst;
  logic       i_slow_clock;
  logic [7:0] i_sfr_addr;
  logic [7:0] i_sfr_wdata;
  logic       i_sfr_wr;
  logic       i_sfr_rd;
  logic       i_irq_service;
  logic [7:0] o_sfr_rdata;
  logic       o_interval_irq;
  logic       o_clear_pending;
  int         n_errors = 0;
  int         checked = 0;
  int         cycles = 0;
  ssit_timer u_ssit_timer (.i_clk(i_clk), .i_rst(i_rst), .i_slow_clock(i_slow_clock),
    .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata), .i_sfr_wr(i_sfr_wr),
    .i_sfr_rd(i_sfr_rd), .i_irq_service(i_irq_service), .o_sfr_rdata(o_sfr_rdata),
    .o_interval_irq(o_interval_irq), .o_clear_pending(o_clear_pending));
  // ****************
  // clock and tasks
  // ****************
  // 40 MHz system clock
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // counts and ends the run
  task automatic give_verdict();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 90000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    i_sfr_wr <= 1'b1;
    @(posedge i_clk);
    i_sfr_wr <= 1'b0;
  endtask
  task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge i_clk);
    i_sfr_addr <= a;
    i_sfr_rd <= 1'b1;
    @(posedge i_clk);
    i_sfr_rd <= 1'b0;
    @(negedge i_clk);
    check(what, exp, o_sfr_rdata);
  endtask
  // one slow period: four cycles high, four low; fast is three high, two low
  task automatic slow_cycles(input int n, input bit fast);
    repeat (n) begin
      @(posedge i_clk);
      i_slow_clock <= 1'b1;
      repeat (fast ? 3 : 4) @(posedge i_clk);
      i_slow_clock <= 1'b0;
      repeat (fast ? 1 : 3) @(posedge i_clk);
    end
  endtask
  task automatic check_irq(input logic exp);
    @(negedge i_clk);
    check("irq", {7'h00, exp}, {7'h00, o_interval_irq});
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset_map();
    sfr_read(8'h94, 8'hC1, "option");
    sfr_read(8'h95, 8'h00, "flag");
    sfr_read(8'hB3, 8'h00, "upper");
    sfr_read(8'hB4, 8'h00, "low");
    sfr_read(8'hB5, 8'h00, "mid");
    sfr_read(8'hB6, 8'h00, "reload");
    sfr_read(8'hB7, 8'h00, "trim");
    sfr_read(8'h00, 8'h00, "unmapped");
  endtask
  task automatic t_reg_access();
    sfr_write(8'hB6, 8'h5A);
    sfr_read(8'hB6, 8'h5A, "reload");
    sfr_write(8'hB7, 8'h85);
    sfr_read(8'hB7, 8'h85, "trim");
    sfr_write(8'hB7, 8'h00);
    sfr_write(8'hB3, 8'hFF);
    sfr_read(8'hB3, 8'h00, "upper");
    sfr_write(8'hB5, 8'hFF);
    sfr_read(8'hB5, 8'h00, "mid");
  endtask
  task automatic t_clear_count();
    sfr_write(8'hF8, 8'h04);
    @(posedge i_clk);
    @(negedge i_clk);
    check("pending", 8'h01, {7'h00, o_clear_pending});
    slow_cycles(1, 1'b0);
    @(negedge i_clk);
    check("pending", 8'h00, {7'h00, o_clear_pending});
    sfr_read(8'hB3, 8'h5A, "upper");
    sfr_read(8'hB4, 8'h00, "low");
    slow_cycles(3, 1'b0);
    sfr_read(8'hB4, 8'h03, "low");
    repeat (20) @(posedge i_clk);
    sfr_read(8'hB4, 8'h03, "low");
  endtask
  task automatic t_interval();
    sfr_write(8'h94, 8'hC3);
    sfr_write(8'hF8, 8'h04);
    slow_cycles(1, 1'b0);
    check_irq(1'b0);
    slow_cycles(8191, 1'b1);
    check_irq(1'b0);
    slow_cycles(1, 1'b0);
    check_irq(1'b1);
    sfr_read(8'h95, 8'h01, "flag");
    sfr_read(8'hB5, 8'h20, "mid");
    repeat (4) @(posedge i_clk);
    sfr_write(8'h95, 8'hFF);
    sfr_read(8'h95, 8'h01, "flag");
    sfr_write(8'h95, 8'hFE);
    sfr_read(8'h95, 8'h00, "flag");
    check_irq(1'b0);
    // second interval with the 16384-cycle select ends at count 4000h
    sfr_write(8'h94, 8'hC2);
    slow_cycles(8191, 1'b1);
    check_irq(1'b0);
    slow_cycles(1, 1'b0);
    check_irq(1'b1);
    repeat (4) @(posedge i_clk);
    @(posedge i_clk);
    i_irq_service <= 1'b1;
    @(posedge i_clk);
    i_irq_service <= 1'b0;
    repeat (2) @(posedge i_clk);
    check_irq(1'b0);
    sfr_read(8'h95, 8'h00, "flag");
  endtask
  // main sequence
  initial begin
    i_rst = 1'b1;
    i_slow_clock = 1'b0;
    i_sfr_addr = 8'h00;
    i_sfr_wdata = 8'h00;
    i_sfr_wr = 1'b0;
    i_sfr_rd = 1'b0;
    i_irq_service = 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset_map();
    t_reg_access();
    t_clear_count();
    t_interval();
    give_verdict();
  end
endmodule
`default_nettype wire

// >>> hw/ssit_pkg.sv
// Purpose: constants and types shared by the slow-clock interval timer
// Assumes: an 8-bit special function register port on the system clock
// Notes:   the constants below are grouped by kind, one line per item
`default_nettype none
package ssit_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int unsigned COUNT_W     = 23;
  localparam int unsigned LOW_W       = 15;
  localparam int unsigned UPPER_W     = 8;
  localparam int unsigned MAG_W       = 7;
  localparam int unsigned TRIM_ACC_W  = 21;  // 2^-21 per step is 0.477 ppm

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] ADDR_OPTION    = 8'h94;
  localparam logic [7:0] ADDR_FLAG      = 8'h95;
  localparam logic [7:0] ADDR_CNT_UPPER = 8'hB3;
  localparam logic [7:0] ADDR_CNT_LOW   = 8'hB4;
  localparam logic [7:0] ADDR_CNT_MID   = 8'hB5;
  localparam logic [7:0] ADDR_RELOAD    = 8'hB6;
  localparam logic [7:0] ADDR_TRIM      = 8'hB7;
  localparam logic [7:0] ADDR_AUX       = 8'hF8;

  // ************************************************************
  // reset values, masks and field positions
  // ************************************************************
  localparam logic [7:0] RST_OPTION     = 8'hC1;
  localparam logic [7:0] RST_RELOAD     = 8'h00;
  localparam logic [7:0] RST_TRIM       = 8'h00;
  localparam logic [7:0] RST_AUX        = 8'h00;
  localparam logic [7:0] AUX_KEEP_MASK  = 8'h1B;  // bits kept for neighbouring blocks
  localparam int unsigned AUX_CLEAR_BIT = 2;
  localparam int unsigned FLAG_BIT      = 0;
  localparam int unsigned TRIM_SIGN_BIT = 7;
  localparam logic [7:0] FLAG_CLEAR_VAL = 8'hFE;

  // interval select encodings
  typedef enum logic [1:0] {
    SSIT_SEL_OVF = 2'b00,
    SSIT_SEL_32K = 2'b01,
    SSIT_SEL_16K = 2'b10,
    SSIT_SEL_8K  = 2'b11
  } ssit_sel_t;

endpackage
`default_nettype wire

// >>> hw/ssit_rate_trim.sv
// Purpose: decide the count step of each slow cycle from the trim setting
// Assumes: i_tick is a one-cycle pulse per slow clock cycle
// Notes:   step is 0, 1 or 2; settles the cycle after each tick
`timescale 1ns/1ps
`default_nettype none
module ssit_rate_trim (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  input  wire logic                     i_tick,
  input  wire logic [ssit_pkg::MAG_W-1:0] i_magnitude,
  input  wire logic                     i_sign,
  output logic      [1:0]               o_step
);

  logic [ssit_pkg::TRIM_ACC_W-1:0] acc_reg;
  logic [ssit_pkg::TRIM_ACC_W:0]   sum;
  logic                            adjust;

  // phase accumulator: carries out magnitude times per 2^21 slow cycles
  always_comb begin
    sum    = {1'b0, acc_reg} + {{(ssit_pkg::TRIM_ACC_W+1-ssit_pkg::MAG_W){1'b0}}, i_magnitude};
    adjust = sum[ssit_pkg::TRIM_ACC_W];
  end

  // advance the phase once per slow cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      acc_reg <= '0;
    end else if (i_tick) begin
      acc_reg <= sum[ssit_pkg::TRIM_ACC_W-1:0];
    end
  end

  // step choice from the sign bit
  always_comb begin
    if (!adjust) begin
      o_step = 2'h1;
    end else if (i_sign) begin
      o_step = 2'h0;
    end else begin
      o_step = 2'h2;
    end
  end

endmodule
`default_nettype wire

// >>> hw/ssit_slow_sync.sv
// Purpose: bring the slow clock pin into the system clock domain
// Assumes: the system clock is at least four times the slow clock
// Notes:   emits a one-cycle pulse per accepted rising edge
`timescale 1ns/1ps
`default_nettype none
module ssit_slow_sync (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_slow_clock,
  output logic      o_tick
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;

  // three-stage synchroniser, first stage read only by the second
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= i_slow_clock;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // accept a change once stages two and three agree, pulse on rise
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      level_reg <= 1'b0;
      o_tick    <= 1'b0;
    end else begin
      o_tick <= 1'b0;
      if (s2_reg == s3_reg && s3_reg != level_reg) begin
        level_reg <= s3_reg;
        o_tick    <= s3_reg;
      end
    end
  end

endmodule
`default_nettype wire

// >>> hw/ssit_timer.sv
// Purpose: slow-clock interval timer with reload, rate trim and interval flag
// Assumes: slow clock arrives on a pin; registers sit on the special function port
// Notes:   the whole block runs on i_clk; slow cycles are one-cycle enables
`timescale 1ns/1ps
`default_nettype none
module ssit_timer (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_slow_clock,
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic [7:0] i_sfr_wdata,
  input  wire logic       i_sfr_wr,
  input  wire logic       i_sfr_rd,
  input  wire logic       i_irq_service,
  output logic      [7:0] o_sfr_rdata,
  output logic            o_interval_irq,
  output logic            o_clear_pending
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic [ssit_pkg::COUNT_W-1:0]   count_reg;
  logic [ssit_pkg::COUNT_W-1:0]   count_next;
  logic [ssit_pkg::UPPER_W-1:0]   reload_reg;
  logic [7:0]                     trim_reg;
  logic [7:0]                     option_reg;
  logic [7:0]                     aux_reg;
  logic                           flag_reg;
  logic                           clear_reg;
  logic [ssit_pkg::COUNT_W:0]     full_sum;
  logic                           overflow;
  logic                           carry_32k;
  logic                           carry_16k;
  logic                           carry_8k;
  logic                           interval_hit;
  logic                           slow_tick;
  logic [1:0]                     step;
  logic                           wr_flag;
  logic                           flag_clear;
  logic [7:0]                     read_mux;
  ssit_pkg::ssit_sel_t            sel;

  // ************************************************************
  // slow clock edge detection and trim
  // ************************************************************

  // slow clock pin becomes a one-cycle enable
  ssit_slow_sync u_sync (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_slow_clock (i_slow_clock),
    .o_tick       (slow_tick)
  );

  // per-cycle step of 0, 1 or 2 from the trim register
  ssit_rate_trim u_trim (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_tick      (slow_tick),
    .i_magnitude (trim_reg[ssit_pkg::MAG_W-1:0]),
    .i_sign      (trim_reg[ssit_pkg::TRIM_SIGN_BIT]),
    .o_step      (step)
  );

  // ************************************************************
  // counter
  // ************************************************************

  // sum with the step, carries into bits 15, 14, 13 and out of bit 22
  always_comb begin
    full_sum  = {1'b0, count_reg} + {{(ssit_pkg::COUNT_W-1){1'b0}}, step};
    overflow  = full_sum[ssit_pkg::COUNT_W];
    carry_32k = full_sum[15] ^ count_reg[15];
    carry_16k = full_sum[14] ^ count_reg[14];
    carry_8k  = full_sum[13] ^ count_reg[13];  // 8192-cycle interval
  end

  // next count value for the coming slow cycle
  always_comb begin
    if (clear_reg) begin
      count_next = {reload_reg, {ssit_pkg::LOW_W{1'b0}}};
    end else if (overflow) begin
      count_next = {reload_reg, {ssit_pkg::LOW_W{1'b0}}};
    end else begin
      count_next = full_sum[ssit_pkg::COUNT_W-1:0];
    end
  end

  // count only on slow clock enables
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count_reg <= '0;
    end else if (slow_tick) begin
      count_reg <= count_next;
    end
  end

  // ************************************************************
  // interval detection
  // ************************************************************

  // pick the interval event from the select field
  always_comb begin
    sel = ssit_pkg::ssit_sel_t'(option_reg[1:0]);
    case (sel)
      ssit_pkg::SSIT_SEL_OVF: interval_hit = overflow;
      ssit_pkg::SSIT_SEL_32K: interval_hit = carry_32k;
      ssit_pkg::SSIT_SEL_16K: interval_hit = carry_16k;
      ssit_pkg::SSIT_SEL_8K:  interval_hit = carry_8k;
      default:                interval_hit = 1'b0;
    endcase
  end

  // ************************************************************
  // register writes
  // ************************************************************

  assign wr_flag    = i_sfr_wr && (i_sfr_addr == ssit_pkg::ADDR_FLAG);
  assign flag_clear = i_irq_service || (wr_flag && !i_sfr_wdata[ssit_pkg::FLAG_BIT]);

  // interval flag: a set in the same cycle beats any clear
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      flag_reg <= 1'b0;
    end else if (slow_tick && !clear_reg && interval_hit) begin
      flag_reg <= 1'b1;
    end else if (flag_clear) begin
      flag_reg <= 1'b0;
    end
  end

  // reload value
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      reload_reg <= ssit_pkg::RST_RELOAD;
    end else if (i_sfr_wr && i_sfr_addr == ssit_pkg::ADDR_RELOAD) begin
      reload_reg <= i_sfr_wdata;
    end
  end

  // trim sign and magnitude
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      trim_reg <= ssit_pkg::RST_TRIM;
    end else if (i_sfr_wr && i_sfr_addr == ssit_pkg::ADDR_TRIM) begin
      trim_reg <= i_sfr_wdata;
    end
  end

  // option byte, interval select in bits 1..0
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      option_reg <= ssit_pkg::RST_OPTION;
    end else if (i_sfr_wr && i_sfr_addr == ssit_pkg::ADDR_OPTION) begin
      option_reg <= i_sfr_wdata;
    end
  end

  // auxiliary byte, the clear bit itself is not stored
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      aux_reg <= ssit_pkg::RST_AUX;
    end else if (i_sfr_wr && i_sfr_addr == ssit_pkg::ADDR_AUX) begin
      aux_reg <= i_sfr_wdata & ssit_pkg::AUX_KEEP_MASK;
    end
  end

  // clear request waits for the next slow cycle; a new write beats completion
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      clear_reg <= 1'b0;
    end else if (i_sfr_wr && i_sfr_addr == ssit_pkg::ADDR_AUX
                 && i_sfr_wdata[ssit_pkg::AUX_CLEAR_BIT]) begin
      clear_reg <= 1'b1;
    end else if (slow_tick) begin
      clear_reg <= 1'b0;
    end
  end

  // ************************************************************
  // register reads
  // ************************************************************

  // live count is returned; software filters a changing value
  always_comb begin
    case (i_sfr_addr)
      ssit_pkg::ADDR_OPTION:    read_mux = option_reg;
      ssit_pkg::ADDR_FLAG:      read_mux = {7'h00, flag_reg};
      ssit_pkg::ADDR_CNT_UPPER: read_mux = count_reg[22:15];
      ssit_pkg::ADDR_CNT_LOW:   read_mux = count_reg[7:0];
      ssit_pkg::ADDR_CNT_MID:   read_mux = {1'b0, count_reg[14:8]};
      ssit_pkg::ADDR_RELOAD:    read_mux = reload_reg;
      ssit_pkg::ADDR_TRIM:      read_mux = trim_reg;
      ssit_pkg::ADDR_AUX:       read_mux = aux_reg;
      default:                  read_mux = 8'h00;
    endcase
  end

  // read data is captured on a read strobe and held until the next
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_sfr_rd) begin
      o_sfr_rdata <= read_mux;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************

  // flag and clear state mirrored into output flops
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_interval_irq  <= 1'b0;
      o_clear_pending <= 1'b0;
    end else begin
      o_interval_irq  <= flag_reg;
      o_clear_pending <= clear_reg;
    end
  end

endmodule
`default_nettype wire
